// file: hdl/cra_cell_alert.sv
// Cell result storage, extreme and sum derivation, voltage alerts and balancing gate
`timescale 1ns/10ps
`include "cra_params.svh"
module cra_cell_alert #(
	parameter int CELLS = 12
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	input  wire logic                   i_scan_start,
	input  wire logic                   i_scan_done,
	input  wire logic [CELLS*12-1:0]    i_cell_data,
	input  wire logic                   i_overtemp,
	output logic [CELLS-1:0]            o_scan_enable,
	output logic [CELLS-1:0]            o_balance_on,
	input  wire logic                   i_link_clock,
	input  wire cra_pkg::cra_addr_t     i_link_addr,
	input  wire cra_pkg::cra_word_t     i_link_wdata,
	input  wire logic                   i_link_wr,
	input  wire logic                   i_link_rd,
	output logic                        o_link_busy,
	output logic                        o_link_done,
	output cra_pkg::cra_word_t          o_link_rdata
);
	import cra_pkg::*;

	// Link domain
	cra_link_state_t link_state_q;
	cra_addr_t       link_addr_q;
	cra_word_t       link_wdata_q;
	logic            link_is_wr_q;
	logic            link_req_q;
	logic            ack_s1_q, ack_s2_q, ack_s3_q;
	logic            ack_lvl_q;
	logic            link_done_q;
	cra_word_t       link_rdata_q;
	// Core domain
	logic            req_s1_q, req_s2_q, req_s3_q;
	logic            req_lvl_q;
	logic            core_ack_q;
	cra_word_t       core_rdata_q;
	logic            req_ev;
	logic            reg_wr;
	cra_word_t       rd_word;
	logic [CELLS-1:0] scan_en_q;
	logic [CELLS-1:0] scan_mask_q;
	logic [CELLS-1:0] ov_en_q, uv_en_q;
	logic [CELLS-1:0] bal_q;
	logic [CELLS-1:0] bal_out_q;
	logic [CELLS-1:0] ov_stat, uv_stat;
	cra_word_t        conv_cfg_q;
	cra_word_t        ov_set_q, ov_clr_q, uv_set_q, uv_clr_q;
	cra_word_t        spread_thr_q;
	cra_word_t        high_q, low_q, sum_q;
	logic             spread_q;
	logic             ot_s1_q, ot_s2_q, ot_s3_q;
	logic             ot_lvl_q;
	cra_sample_t      smp    [CELLS];
	cra_sample_t      data_q [CELLS];
	cra_sample_t      hi_val, lo_val;
	logic [3:0]       hi_idx, lo_idx;
	logic [15:0]      sum_val;
	logic             any_cell;
	logic             ov_any, uv_any;

	// Link side: hold the access stable until the core acknowledges it
	always_ff @(posedge i_link_clock or posedge i_rst) begin
		if (i_rst) begin
			link_state_q <= CRA_LINK_IDLE;
			link_addr_q  <= '0;
			link_wdata_q <= '0;
			link_is_wr_q <= 1'b0;
			link_req_q   <= 1'b0;
			link_done_q  <= 1'b0;
			link_rdata_q <= '0;
		end else begin
			link_done_q <= 1'b0;
			unique case (link_state_q)
				CRA_LINK_IDLE: begin
					if (i_link_wr || i_link_rd) begin
						link_addr_q  <= i_link_addr;
						link_wdata_q <= i_link_wdata;
						link_is_wr_q <= i_link_wr;
						link_req_q   <= ~link_req_q;
						link_state_q <= CRA_LINK_WAIT;
					end
				end
				CRA_LINK_WAIT: begin
					if (ack_lvl_q == link_req_q) begin
						// One register word, two data bytes on the ladder
						link_rdata_q <= core_rdata_q;
						link_done_q  <= 1'b1;
						link_state_q <= CRA_LINK_IDLE;
					end
				end
			endcase
		end
	end

	// Acknowledge toggle into the link domain; level accepted once stages two and three agree
	always_ff @(posedge i_link_clock or posedge i_rst) begin
		if (i_rst) begin
			ack_s1_q  <= 1'b0;
			ack_s2_q  <= 1'b0;
			ack_s3_q  <= 1'b0;
			ack_lvl_q <= 1'b0;
		end else begin
			ack_s1_q <= core_ack_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			if (ack_s2_q == ack_s3_q) begin
				ack_lvl_q <= ack_s3_q;
			end
		end
	end

	assign o_link_busy  = (link_state_q == CRA_LINK_WAIT);
	assign o_link_done  = link_done_q;
	assign o_link_rdata = link_rdata_q;

	// Request toggle into the core domain
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			req_s1_q  <= 1'b0;
			req_s2_q  <= 1'b0;
			req_s3_q  <= 1'b0;
			req_lvl_q <= 1'b0;
		end else begin
			req_s1_q <= link_req_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			if (req_ev) begin
				req_lvl_q <= req_s3_q;
			end
		end
	end

	assign req_ev = (req_s2_q == req_s3_q) && (req_s3_q != req_lvl_q);
	assign reg_wr = req_ev && link_is_wr_q;

	// Read data is captured on the same edge as the acknowledge toggles; the ack synchroniser delay lets the link see it settled
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			core_ack_q   <= 1'b0;
			core_rdata_q <= '0;
		end else if (req_ev) begin
			core_ack_q <= req_s3_q;
			if (!link_is_wr_q) begin
				core_rdata_q <= rd_word;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			conv_cfg_q   <= `CRA_RST_ZERO;
			scan_en_q    <= CELLS'(`CRA_RST_ZERO);
			bal_q        <= CELLS'(`CRA_RST_ZERO);
			ov_set_q     <= `CRA_RST_OV_SET;
			ov_clr_q     <= `CRA_RST_OV_CLR;
			uv_set_q     <= `CRA_RST_UV_SET;
			uv_clr_q     <= `CRA_RST_UV_CLR;
			spread_thr_q <= `CRA_RST_SPREAD;
		end else if (reg_wr) begin
			unique case (link_addr_q)
				`CRA_OFS_CONV_CFG: conv_cfg_q   <= link_wdata_q;
				`CRA_OFS_SCAN_EN:  scan_en_q    <= link_wdata_q[CELLS-1:0];
				`CRA_OFS_BAL_CTRL: bal_q        <= link_wdata_q[CELLS-1:0];
				`CRA_OFS_OV_SET:   ov_set_q     <= link_wdata_q;
				`CRA_OFS_OV_CLR:   ov_clr_q     <= link_wdata_q;
				`CRA_OFS_UV_SET:   uv_set_q     <= link_wdata_q;
				`CRA_OFS_UV_CLR:   uv_clr_q     <= link_wdata_q;
				`CRA_OFS_SPREAD:   spread_thr_q <= link_wdata_q;
				default: ;
			endcase
		end
	end

	// One storage for the alert enables, reachable from both the enable and cell registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ov_en_q <= CELLS'(`CRA_RST_ZERO);
			uv_en_q <= CELLS'(`CRA_RST_ZERO);
		end else if (reg_wr) begin
			if (link_addr_q == `CRA_OFS_OV_EN) begin
				ov_en_q <= link_wdata_q[CELLS-1:0];
			end
			if (link_addr_q == `CRA_OFS_UV_EN) begin
				uv_en_q <= link_wdata_q[CELLS-1:0];
			end
			for (int i = 0; i < CELLS; i++) begin
				if (link_addr_q == `CRA_OFS_CELL_BASE + 8'(i)) begin
					ov_en_q[i] <= link_wdata_q[`CRA_CELL_OV_EN_BIT];
					uv_en_q[i] <= link_wdata_q[`CRA_CELL_UV_EN_BIT];
				end
			end
		end
	end

	assign o_scan_enable = scan_en_q;

	// Cells of a scan are fixed when it starts, so later enable writes cannot mix in
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			scan_mask_q <= CELLS'(`CRA_RST_ZERO);
		end else if (i_scan_start) begin
			scan_mask_q <= scan_en_q;
		end
	end

	// Per-cell data and alert state
	for (genvar c = 0; c < CELLS; c++) begin : g_cell
		logic ov_q;
		logic uv_q;
		assign smp[c] = i_cell_data[c*12 +: 12];

		always_ff @(posedge i_clock or posedge i_rst) begin
			if (i_rst) begin
				data_q[c] <= '0;
			end else if (i_scan_done && scan_mask_q[c]) begin
				data_q[c] <= smp[c];
			end
		end

		// Strict compares only: a reading on a threshold holds the state
		always_ff @(posedge i_clock or posedge i_rst) begin
			if (i_rst) begin
				ov_q <= 1'b0;
			end else if (!ov_en_q[c]) begin
				ov_q <= 1'b0;
			end else if (i_scan_done && scan_mask_q[c]) begin
				if (smp[c] > ov_set_q[`CRA_DATA_MSB:`CRA_DATA_LSB]) begin
					ov_q <= 1'b1;
				end else if (smp[c] < ov_clr_q[`CRA_DATA_MSB:`CRA_DATA_LSB]) begin
					ov_q <= 1'b0;
				end
			end
		end

		always_ff @(posedge i_clock or posedge i_rst) begin
			if (i_rst) begin
				uv_q <= 1'b0;
			end else if (!uv_en_q[c]) begin
				uv_q <= 1'b0;
			end else if (i_scan_done && scan_mask_q[c]) begin
				if (smp[c] < uv_set_q[`CRA_DATA_MSB:`CRA_DATA_LSB]) begin
					uv_q <= 1'b1;
				end else if (smp[c] > uv_clr_q[`CRA_DATA_MSB:`CRA_DATA_LSB]) begin
					uv_q <= 1'b0;
				end
			end
		end

		assign ov_stat[c] = ov_q;
		assign uv_stat[c] = uv_q;
	end

	assign ov_any = |ov_stat;
	assign uv_any = |uv_stat;

	// Extremes and sum over the cells of the finishing scan
	always_comb begin
		hi_val   = '0;
		lo_val   = '0;
		hi_idx   = '0;
		lo_idx   = '0;
		sum_val  = '0;
		any_cell = 1'b0;
		for (int i = 0; i < CELLS; i++) begin
			if (scan_mask_q[i]) begin
				// Ascending walk with >= and <= lets a tie fall to the higher cell
				if (!any_cell || smp[i] >= hi_val) begin
					hi_val = smp[i];
					hi_idx = 4'(i + 1);
				end
				if (!any_cell || smp[i] <= lo_val) begin
					lo_val = smp[i];
					lo_idx = 4'(i + 1);
				end
				sum_val  = sum_val + 16'(smp[i]);
				any_cell = 1'b1;
			end
		end
	end

	// Derived results all move on the scan-done edge
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			high_q <= `CRA_RST_ZERO;
			low_q  <= `CRA_RST_ZERO;
			sum_q  <= `CRA_RST_ZERO;
		end else if (i_scan_done && any_cell) begin
			high_q <= {hi_val, hi_idx};
			low_q  <= {lo_val, lo_idx};
			sum_q  <= sum_val;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			spread_q <= 1'b0;
		end else if (!conv_cfg_q[`CRA_CFG_SPREAD_BIT]) begin
			spread_q <= 1'b0;
		end else if (i_scan_done && any_cell) begin
			spread_q <= (hi_val - lo_val) > spread_thr_q[`CRA_DATA_MSB:`CRA_DATA_LSB];
		end
	end

	// Overtemperature from the analog side; only the agreed level is used
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ot_s1_q  <= 1'b0;
			ot_s2_q  <= 1'b0;
			ot_s3_q  <= 1'b0;
			ot_lvl_q <= 1'b0;
		end else begin
			ot_s1_q <= i_overtemp;
			ot_s2_q <= ot_s1_q;
			ot_s3_q <= ot_s2_q;
			if (ot_s2_q == ot_s3_q) begin
				ot_lvl_q <= ot_s3_q;
			end
		end
	end

	// Gate is separate from the control bits, which survive the overtemperature event
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bal_out_q <= CELLS'(`CRA_RST_ZERO);
		end else begin
			bal_out_q <= ot_lvl_q ? CELLS'(`CRA_RST_ZERO) : bal_q;
		end
	end

	assign o_balance_on = bal_out_q;

	// Register read view; status registers have no write path at all
	always_comb begin
		rd_word = '0;
		unique case (link_addr_q)
			`CRA_OFS_STATUS: begin
				rd_word[`CRA_ST_OV_BIT]     = ov_any;
				rd_word[`CRA_ST_UV_BIT]     = uv_any;
				rd_word[`CRA_ST_SPREAD_BIT] = spread_q;
			end
			`CRA_OFS_ALERT_SUM: rd_word[CELLS-1:0] = ov_stat | uv_stat;
			`CRA_OFS_OV_STAT:   rd_word[CELLS-1:0] = ov_stat;
			`CRA_OFS_UV_STAT:   rd_word[CELLS-1:0] = uv_stat;
			`CRA_OFS_OV_EN:     rd_word[CELLS-1:0] = ov_en_q;
			`CRA_OFS_UV_EN:     rd_word[CELLS-1:0] = uv_en_q;
			`CRA_OFS_CONV_CFG:  rd_word = conv_cfg_q;
			`CRA_OFS_SCAN_EN:   rd_word[CELLS-1:0] = scan_en_q;
			`CRA_OFS_BAL_CTRL:  rd_word[CELLS-1:0] = bal_q;
			`CRA_OFS_SUM:       rd_word = sum_q;
			`CRA_OFS_HIGH:      rd_word = high_q;
			`CRA_OFS_LOW:       rd_word = low_q;
			`CRA_OFS_OV_SET:    rd_word = ov_set_q;
			`CRA_OFS_OV_CLR:    rd_word = ov_clr_q;
			`CRA_OFS_UV_SET:    rd_word = uv_set_q;
			`CRA_OFS_UV_CLR:    rd_word = uv_clr_q;
			`CRA_OFS_SPREAD:    rd_word = spread_thr_q;
			default: begin
				for (int i = 0; i < CELLS; i++) begin
					if (link_addr_q == `CRA_OFS_CELL_BASE + 8'(i)) begin
						rd_word[`CRA_DATA_MSB:`CRA_DATA_LSB] = data_q[i];
						rd_word[`CRA_CELL_OV_EN_BIT]         = ov_en_q[i];
						rd_word[`CRA_CELL_UV_EN_BIT]         = uv_en_q[i];
					end
				end
			end
		endcase
	end
endmodule

// file: hdl/cra_params.svh
// Register offsets, field positions and reset values of the cell result and alert logic
`ifndef CRA_PARAMS_SVH
`define CRA_PARAMS_SVH

`define CRA_OFS_STATUS      8'h02
`define CRA_OFS_ALERT_SUM   8'h03
`define CRA_OFS_OV_STAT     8'h04
`define CRA_OFS_UV_STAT     8'h05
`define CRA_OFS_OV_EN       8'h06
`define CRA_OFS_UV_EN       8'h07
`define CRA_OFS_CONV_CFG    8'h08
`define CRA_OFS_SCAN_EN     8'h09
`define CRA_OFS_BAL_CTRL    8'h0B
`define CRA_OFS_SUM         8'h10
`define CRA_OFS_HIGH        8'h11
`define CRA_OFS_LOW         8'h12
`define CRA_OFS_OV_SET      8'h18
`define CRA_OFS_OV_CLR      8'h19
`define CRA_OFS_UV_SET      8'h1A
`define CRA_OFS_UV_CLR      8'h1B
`define CRA_OFS_SPREAD      8'h1C
`define CRA_OFS_CELL_BASE   8'h20

`define CRA_DATA_LSB        4
`define CRA_DATA_MSB        15
`define CRA_CELL_OV_EN_BIT  1
`define CRA_CELL_UV_EN_BIT  0
`define CRA_ST_OV_BIT       2
`define CRA_ST_UV_BIT       1
`define CRA_ST_SPREAD_BIT   0
`define CRA_CFG_SPREAD_BIT  7

`define CRA_RST_ZERO        16'h0000
`define CRA_RST_OV_SET      16'hFFF0
`define CRA_RST_OV_CLR      16'hFFF0
`define CRA_RST_UV_SET      16'h0000
`define CRA_RST_UV_CLR      16'h0000
`define CRA_RST_SPREAD      16'hFFF0

`endif

// file: hdl/cra_pkg.sv
// Types shared by the cell result and alert logic
package cra_pkg;
	typedef logic [15:0] cra_word_t;
	typedef logic [11:0] cra_sample_t;
	typedef logic [7:0]  cra_addr_t;
	typedef enum logic {
		CRA_LINK_IDLE,
		CRA_LINK_WAIT
	} cra_link_state_t;
endpackage

// file: test/cra_cell_alert_props.sv
// Port-level assertions for the cell result and alert logic
`timescale 1ns/10ps
module cra_cell_alert_props #(
	parameter int CELLS = 12
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire logic               i_overtemp,
	input  wire logic [CELLS-1:0]   o_balance_on,
	input  wire logic               i_link_clock,
	input  wire logic               i_link_wr,
	input  wire logic               i_link_rd,
	input  wire logic               o_link_busy,
	input  wire logic               o_link_done,
	input  wire cra_pkg::cra_word_t o_link_rdata
);
	import cra_pkg::*;
	sequence s_take;
		(i_link_wr || i_link_rd) && !o_link_busy;
	endsequence
	// Eight cycles covers the synchroniser and the output register
	sequence s_hot;
		i_overtemp [*8];
	endsequence
	chk_hot_all_off: assert property (@(posedge i_clock) disable iff (i_rst)
		s_hot |-> o_balance_on == '0) else $error("switch on in overtemperature");
	chk_take_busy: assert property (@(posedge i_link_clock) disable iff (i_rst)
		s_take |=> o_link_busy) else $error("request taken without busy");
	chk_take_answer: assert property (@(posedge i_link_clock) disable iff (i_rst)
		s_take |-> ##[2:12] o_link_done) else $error("no answer in time");
	chk_done_idle: assert property (@(posedge i_link_clock) disable iff (i_rst)
		o_link_done |-> !o_link_busy) else $error("busy high at done");
	chk_done_single: assert property (@(posedge i_link_clock) disable iff (i_rst)
		o_link_done |=> !o_link_done) else $error("done too long");
	chk_done_cause: assert property (@(posedge i_link_clock) disable iff (i_rst)
		o_link_done |-> $past(o_link_busy)) else $error("done without request");
	chk_busy_end: assert property (@(posedge i_link_clock) disable iff (i_rst)
		$fell(o_link_busy) |-> o_link_done) else $error("busy fell without done");
	chk_word_hold: assert property (@(posedge i_link_clock) disable iff (i_rst)
		$changed(o_link_rdata) |-> o_link_done) else $error("read word moved");
endmodule

bind cra_cell_alert cra_cell_alert_props #(.CELLS(CELLS)) u_props (
	.i_clock(i_clock), .i_rst(i_rst), .i_overtemp(i_overtemp), .o_balance_on(o_balance_on),
	.i_link_clock(i_link_clock), .i_link_wr(i_link_wr), .i_link_rd(i_link_rd),
	.o_link_busy(o_link_busy), .o_link_done(o_link_done), .o_link_rdata(o_link_rdata)
);

// file: test/cra_host_model.sv
// Host controller model issuing one-word register accesses on the link clock
`timescale 1ns/10ps
`include "cra_params.svh"
module cra_host_model (
	input  wire logic               i_link_clock,
	input  wire logic               i_link_done,
	input  wire cra_pkg::cra_word_t i_link_rdata,
	output cra_pkg::cra_addr_t      o_link_addr,
	output cra_pkg::cra_word_t      o_link_wdata,
	output logic                    o_link_wr,
	output logic                    o_link_rd
);
	import cra_pkg::*;
	initial begin
		o_link_addr = 8'h00;
		o_link_wdata = 16'h0000;
		o_link_wr = 1'b0;
		o_link_rd = 1'b0;
	end
	// One register per command, returned whole as its two data bytes
	task automatic access(input cra_addr_t a, input cra_word_t d, input logic w,
		output cra_word_t q);
		// Avoids overheating: at most two nonadjacent switches
		if (w && a == `CRA_OFS_BAL_CTRL && ($countones(d) > 2 || (d & (d << 1)) != 16'h0000)) begin
			d = 16'h0000;
		end
		@(posedge i_link_clock);
		o_link_addr <= a;
		o_link_wdata <= d;
		o_link_wr <= w;
		o_link_rd <= !w;
		@(posedge i_link_clock);
		o_link_wr <= 1'b0;
		o_link_rd <= 1'b0;
		// Released lines show the inverse so a stale value cannot pass
		o_link_addr <= ~a;
		o_link_wdata <= ~d;
		// A lost answer waits here, so the bench timeout counts it as a mismatch
		#1;
		while (i_link_done !== 1'b1) begin
			@(posedge i_link_clock);
			#1;
		end
		q = i_link_rdata;
	endtask
endmodule

// file: test/tb_cell_result_alert_logic.sv
// Self-checking bench of the cell result and alert logic
`timescale 1ns/10ps
`include "cra_params.svh"
module tb_cell_result_alert_logic;
	import cra_pkg::*;
	logic         i_clock, i_link_clock, i_rst, i_scan_start, i_scan_done, i_overtemp;
	logic         l_wr, l_rd, l_busy, l_done, sp_q;
	logic [143:0] i_cell_data;
	logic [11:0]  scan_en, bal_on, ov_q, uv_q, ov_en, uv_en;
	logic [11:0]  cell_q [12];
	cra_addr_t    l_addr;
	cra_word_t    l_wdata, l_rdata, q, hi_q, lo_q, sum_q;
	int           n_mismatch, n_tests, seed, cyc;

	cra_cell_alert #(.CELLS(12)) u_dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_scan_start(i_scan_start), .i_scan_done(i_scan_done), .i_cell_data(i_cell_data),
		.i_overtemp(i_overtemp), .o_scan_enable(scan_en), .o_balance_on(bal_on),
		.i_link_clock(i_link_clock), .i_link_addr(l_addr), .i_link_wdata(l_wdata),
		.i_link_wr(l_wr), .i_link_rd(l_rd), .o_link_busy(l_busy), .o_link_done(l_done),
		.o_link_rdata(l_rdata));
	cra_host_model u_host (.i_link_clock(i_link_clock), .i_link_done(l_done),
		.i_link_rdata(l_rdata), .o_link_addr(l_addr), .o_link_wdata(l_wdata),
		.o_link_wr(l_wr), .o_link_rd(l_rd));

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	// Odd offset keeps link edges off core edges; the first rise falls inside reset
	initial begin
		i_link_clock = 1'b0;
		#13;
		forever begin
			i_link_clock = ~i_link_clock;
			#80;
		end
	end

	function automatic logic nx_ov(logic cur, logic [11:0] v);
		return (v > 12'hC00) ? 1'b1 : (v < 12'hB00) ? 1'b0 : cur;
	endfunction
	function automatic logic nx_uv(logic cur, logic [11:0] v);
		return (v < 12'h300) ? 1'b1 : (v > 12'h400) ? 1'b0 : cur;
	endfunction

	task automatic close_out();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk_reg(input cra_word_t e, input cra_word_t g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t reg exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_bits(input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t pins exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input cra_addr_t a, input cra_word_t d);
		u_host.access(a, d, 1'b1, q);
	endtask
	task automatic rc(input cra_addr_t a, input cra_word_t e);
		u_host.access(a, 16'h0000, 1'b0, q);
		chk_reg(e, q);
	endtask

	task automatic scan(input int k, input logic [11:0] m);
		logic [11:0] d [12];
		logic [11:0] hv, lv;
		logic [3:0]  hc, lc;
		cra_word_t   s;
		wr(`CRA_OFS_SCAN_EN, {4'h0, m});
		hv = 12'h000;
		lv = 12'hFFF;
		hc = 4'h0;
		lc = 4'h0;
		s = 16'h0000;
		for (int c = 0; c < 12; c++) begin
			// Whole-scan values on thresholds and ties
			d[c] = (k == 1) ? 12'hB00 : (k == 2) ? 12'hC00 : 12'($random(seed));
			if (m[c]) begin
				cell_q[c] = d[c];
				ov_q[c] = ov_en[c] & nx_ov(ov_q[c], d[c]);
				uv_q[c] = uv_en[c] & nx_uv(uv_q[c], d[c]);
				s = s + {4'h0, d[c]};
				if (d[c] >= hv) begin
					hv = d[c];
					hc = 4'(c + 1);
				end
				if (d[c] <= lv) begin
					lv = d[c];
					lc = 4'(c + 1);
				end
			end
		end
		if (m != 12'h000) begin
			hi_q = {hv, hc};
			lo_q = {lv, lc};
			sum_q = s;
			sp_q = (hv - lv) > 12'h600;
		end
		@(posedge i_clock);
		i_scan_start <= 1'b1;
		@(posedge i_clock);
		i_scan_start <= 1'b0;
		repeat (4) @(posedge i_clock);
		i_scan_done <= 1'b1;
		for (int c = 0; c < 12; c++) begin
			i_cell_data[c*12 +: 12] <= d[c];
		end
		@(posedge i_clock);
		i_scan_done <= 1'b0;
		i_cell_data <= ~i_cell_data;
		@(negedge i_clock);
		chk_bits(m, scan_en);
		rc(`CRA_OFS_SUM, sum_q);
		rc(`CRA_OFS_HIGH, hi_q);
		rc(`CRA_OFS_LOW, lo_q);
		rc(`CRA_OFS_OV_STAT, {4'h0, ov_q});
		rc(`CRA_OFS_UV_STAT, {4'h0, uv_q});
		rc(`CRA_OFS_ALERT_SUM, {4'h0, ov_q | uv_q});
		rc(`CRA_OFS_STATUS, {13'h0000, |ov_q, |uv_q, sp_q});
		for (int c = 0; c < 12; c++) begin
			rc(`CRA_OFS_CELL_BASE + 8'(c), {cell_q[c], 2'h0, ov_en[c], uv_en[c]});
		end
		$display("test scan %0d done", k);
	endtask

	initial begin
		cyc = 0;
		forever begin
			@(posedge i_clock);
			cyc++;
			if (cyc == 60000) begin
				n_mismatch++;
				close_out();
			end
		end
	end

	initial begin
		cra_word_t p;
		seed = 42753;
		n_mismatch = 0;
		n_tests = 0;
		i_rst = 1'b1;
		i_scan_start = 1'b0;
		i_scan_done = 1'b0;
		i_overtemp = 1'b0;
		i_cell_data = '0;
		{ov_q, uv_q, ov_en, uv_en, sp_q} = '0;
		{hi_q, lo_q, sum_q} = '0;
		foreach (cell_q[c]) cell_q[c] = 12'h000;
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		rc(`CRA_OFS_OV_CLR, 16'hFFF0);
		rc(`CRA_OFS_UV_SET, 16'h0000);
		rc(`CRA_OFS_SPREAD, 16'hFFF0);
		rc(8'h0F, 16'h0000);
		$display("test reset done");
		wr(`CRA_OFS_OV_SET, 16'hC000);
		wr(`CRA_OFS_OV_CLR, 16'hB000);
		wr(`CRA_OFS_UV_SET, 16'h3000);
		wr(`CRA_OFS_UV_CLR, 16'h4000);
		wr(`CRA_OFS_SPREAD, 16'h6000);
		wr(`CRA_OFS_CONV_CFG, 16'h0080);
		ov_en = 12'hFFD;
		uv_en = 12'($random(seed));
		wr(`CRA_OFS_OV_EN, {4'h0, ov_en});
		wr(`CRA_OFS_UV_EN, {4'h0, uv_en});
		wr(`CRA_OFS_CELL_BASE + 8'h01, 16'hFFFF);
		ov_en[1] = 1'b1;
		uv_en[1] = 1'b1;
		rc(`CRA_OFS_OV_EN, {4'h0, ov_en});
		rc(`CRA_OFS_UV_EN, {4'h0, uv_en});
		for (int k = 0; k < 6; k++) begin
			scan(k, (k == 3) ? 12'h000 : (k < 3) ? 12'hFFF : 12'($random(seed)));
		end
		wr(`CRA_OFS_UV_STAT, 16'hFFFF);
		rc(`CRA_OFS_UV_STAT, {4'h0, uv_q});
		wr(`CRA_OFS_OV_EN, 16'h0000);
		ov_en = 12'h000;
		ov_q = 12'h000;
		rc(`CRA_OFS_OV_STAT, 16'h0000);
		rc(`CRA_OFS_CELL_BASE, {cell_q[0], 3'h0, uv_en[0]});
		wr(`CRA_OFS_CONV_CFG, 16'h0000);
		sp_q = 1'b0;
		rc(`CRA_OFS_STATUS, {13'h0000, |ov_q, |uv_q, sp_q});
		$display("test alert clear done");
		for (int i = 0; i < 2; i++) begin
			p = (i == 0) ? 16'h0005 : 16'h0840;
			wr(`CRA_OFS_BAL_CTRL, p);
			@(negedge i_clock);
			chk_bits(p[11:0], bal_on);
			@(posedge i_clock);
			i_overtemp <= 1'b1;
			repeat (10) @(negedge i_clock);
			chk_bits(12'h000, bal_on);
			rc(`CRA_OFS_BAL_CTRL, p);
			@(posedge i_clock);
			i_overtemp <= 1'b0;
			repeat (10) @(negedge i_clock);
			chk_bits(p[11:0], bal_on);
		end
		$display("test balance done");
		close_out();
	end
endmodule
